// ==== ccio_io_decode.sv ====
module ccio_io_decode
  import ccio_pkg::*;
#(
  parameter int unsigned CLK_HZ      = CLK_HZ_DEF,
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Processor I/O instruction
  input  wire logic       io_strobe,
  input  wire logic       io_output,
  input  wire logic [7:0] io_operand,
  input  wire logic [7:0] io_acc,
  // Status events from the rest of the controller
  input  wire logic       host_reset_key,
  input  wire logic       tx_underflow_set,
  input  wire logic       rx_overflow_set,
  input  wire logic       parity_err_set,
  input  wire logic       framing_err_set,
  input  wire logic       tx_ready_set,
  input  wire logic       rx_ready,
  // Modem timing and serial data
  input  wire logic       tx_timing,
  input  wire logic       rx_timing,
  input  wire logic       self_test_en,
  input  wire logic       tx_serial,
  input  wire logic       modem_rx_data,
  // Data-link control
  output logic            rts,
  output logic            dtr,
  output logic            tx_int_en,
  output logic            rx_int_en,
  output logic            sup_tx_data,
  output logic [2:0]      rate_sel,
  output logic            ext_clock_sel,
  // Host input bus
  output logic [7:0]      host_bus_data,
  output logic            host_input_strobe,
  output logic            end_of_input_flag,
  // Character registers
  output logic [7:0]      fill_char,
  output logic [7:0]      tx_buf_data,
  output logic            tx_buf_load,
  output logic [7:0]      sync_match,
  output logic            rx_resync,
  // Display connector
  output logic [6:0]      display_data,
  output logic            display_strobe,
  output logic            display_home,
  // Transmitter format
  output logic [1:0]      tx_mode,
  output logic [1:0]      tx_char_bits,
  output logic            tx_parity_en,
  output logic            tx_parity_even,
  output logic [1:0]      tx_div,
  // Receiver format
  output logic            rx_sync_mode,
  output logic [1:0]      rx_char_bits,
  output logic            rx_parity_en,
  output logic            rx_parity_even,
  output logic [1:0]      rx_div,
  // Bit clocks and receive path
  output logic            tx_bit_tick,
  output logic            rx_bit_tick,
  output logic            rx_serial_in,
  // Status flags
  output logic            reset_key_flag,
  output logic            tick_flag,
  output logic            tx_underflow,
  output logic            rx_overflow,
  output logic            parity_err,
  output logic            framing_err,
  output logic            tx_ready,
  output logic            irq
);

  logic [7:0] dlc_reg;
  logic [7:0] dlc_next;
  logic [7:0] txf_reg;
  logic [7:0] txf_next;
  logic [7:0] rxf_reg;
  logic [7:0] rxf_next;
  logic [7:0] fill_reg;
  logic [7:0] fill_next;
  logic [7:0] txbuf_reg;
  logic [7:0] txbuf_next;
  logic [7:0] sync_reg;
  logic [7:0] sync_next;
  logic [7:0] host_reg;
  logic [7:0] host_next;
  logic       eoi_reg;
  logic       eoi_next;
  logic       ibs_reg;
  logic       ibs_next;
  logic [7:0] disp_reg;
  logic [7:0] disp_next;
  logic       dstb_reg;
  logic       dstb_next;
  logic       txld_reg;
  logic       txld_next;
  logic       resync_reg;
  logic       resync_next;
  logic       loop_reg;
  logic       loop_next;

  logic       rkey_reg;
  logic       rkey_next;
  logic       tick_reg;
  logic       tick_next;
  logic       unf_reg;
  logic       unf_next;
  logic       ovf_reg;
  logic       ovf_next;
  logic       par_reg;
  logic       par_next;
  logic       frm_reg;
  logic       frm_next;
  logic       txr_reg;
  logic       txr_next;

  logic       rt_tick;
  logic [2:0] op_code;
  logic       wr;
  logic       clr_rkey;
  logic       clr_tick;
  logic       clr_err;

  ccio_tick_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (rt_tick)
  );

  // Separate dividers: each side has its own divide field
  ccio_rate_gen #(
    .CLK_HZ (CLK_HZ)
  ) u_tx_rate (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .rate_sel   (dlc_reg[DLC_RATE_LO +: 3]),
    .div_sel    (txf_reg[FMT_DIV_LO +: 2]),
    .ext_timing (tx_timing),
    .bit_tick   (tx_bit_tick)
  );

  ccio_rate_gen #(
    .CLK_HZ (CLK_HZ)
  ) u_rx_rate (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .rate_sel   (dlc_reg[DLC_RATE_LO +: 3]),
    .div_sel    (rxf_reg[FMT_DIV_LO +: 2]),
    .ext_timing (rx_timing),
    .bit_tick   (rx_bit_tick)
  );

  // Control strobes act on input and output instructions alike
  always_comb
  begin
    op_code  = io_operand[OPB_CODE_HI:0];
    wr       = io_strobe & io_output;
    clr_rkey = io_strobe & io_operand[OPB_CLR_RESET_KEY];
    clr_tick = io_strobe & io_operand[OPB_CLR_TICK];
    clr_err  = io_strobe & io_operand[OPB_CLR_ERRORS];
  end

  // Output operations
  always_comb
  begin
    dlc_next    = dlc_reg;
    txf_next    = txf_reg;
    rxf_next    = rxf_reg;
    fill_next   = fill_reg;
    txbuf_next  = txbuf_reg;
    sync_next   = sync_reg;
    host_next   = host_reg;
    eoi_next    = eoi_reg;
    disp_next   = disp_reg;
    ibs_next    = 1'b0;
    dstb_next   = 1'b0;
    txld_next   = 1'b0;
    resync_next = io_strobe & io_operand[OPB_SYNC_SEARCH];
    if (wr)
    begin
      unique case (op_code)
        OP_DATA_LINK_CONTROL: dlc_next = io_acc;
        OP_HOST_OUTPUT_DATA:
        begin
          host_next = io_acc;
          eoi_next  = io_operand[OPB_END_OF_INPUT];
          ibs_next  = 1'b1;
        end
        OP_TX_FILL_CHARACTER: fill_next = io_acc;
        OP_TX_DATA_BUFFER:
        begin
          txbuf_next = io_acc;
          txld_next  = 1'b1;
        end
        OP_DISPLAY_OUTPUT:
        begin
          disp_next = io_acc;
          dstb_next = 1'b1;
        end
        OP_RX_SYNC_MATCH:     sync_next = io_acc;
        OP_TX_FORMAT_CONTROL: txf_next  = io_acc;
        OP_RX_FORMAT_CONTROL: rxf_next  = io_acc;
      endcase
    end
  end

  // Status flags: a set in the clearing cycle wins
  always_comb
  begin
    rkey_next = host_reset_key | (rkey_reg & ~clr_rkey);
    tick_next = rt_tick | (tick_reg & ~clr_tick);
    unf_next  = tx_underflow_set | (unf_reg & ~clr_err);
    ovf_next  = rx_overflow_set | (ovf_reg & ~clr_err);
    par_next  = parity_err_set | (par_reg & ~clr_err);
    frm_next  = framing_err_set | (frm_reg & ~clr_err);
    // Buffer load clears ready; a transfer at the same edge sets it
    if (tx_ready_set)
      txr_next = 1'b1;
    else if (wr && op_code == OP_TX_DATA_BUFFER)
      txr_next = 1'b0;
    else
      txr_next = txr_reg;
    // Loopback sampled each cycle so the receiver sees a clean register
    loop_next = self_test_en ? tx_serial : modem_rx_data;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dlc_reg    <= DLC_RESET;
      txf_reg    <= FMT_RESET;
      rxf_reg    <= FMT_RESET;
      fill_reg   <= CHAR_RESET;
      txbuf_reg  <= CHAR_RESET;
      sync_reg   <= CHAR_RESET;
      host_reg   <= CHAR_RESET;
      eoi_reg    <= 1'b0;
      ibs_reg    <= 1'b0;
      disp_reg   <= CHAR_RESET;
      dstb_reg   <= 1'b0;
      txld_reg   <= 1'b0;
      resync_reg <= 1'b0;
      loop_reg   <= 1'b1;
      rkey_reg   <= 1'b0;
      tick_reg   <= 1'b0;
      unf_reg    <= 1'b0;
      ovf_reg    <= 1'b0;
      par_reg    <= 1'b0;
      frm_reg    <= 1'b0;
      txr_reg    <= 1'b1;
    end
    else
    begin
      dlc_reg    <= dlc_next;
      txf_reg    <= txf_next;
      rxf_reg    <= rxf_next;
      fill_reg   <= fill_next;
      txbuf_reg  <= txbuf_next;
      sync_reg   <= sync_next;
      host_reg   <= host_next;
      eoi_reg    <= eoi_next;
      ibs_reg    <= ibs_next;
      disp_reg   <= disp_next;
      dstb_reg   <= dstb_next;
      txld_reg   <= txld_next;
      resync_reg <= resync_next;
      loop_reg   <= loop_next;
      rkey_reg   <= rkey_next;
      tick_reg   <= tick_next;
      unf_reg    <= unf_next;
      ovf_reg    <= ovf_next;
      par_reg    <= par_next;
      frm_reg    <= frm_next;
      txr_reg    <= txr_next;
    end
  end

  assign rts           = dlc_reg[DLC_RTS];
  assign dtr           = dlc_reg[DLC_DTR];
  assign tx_int_en     = dlc_reg[DLC_TX_IE];
  assign rx_int_en     = dlc_reg[DLC_RX_IE];
  assign sup_tx_data   = dlc_reg[DLC_SUP_TX];
  assign rate_sel      = dlc_reg[DLC_RATE_LO +: 3];
  assign ext_clock_sel = (rate_sel == RATE_EXTERNAL);

  assign host_bus_data     = host_reg;
  assign host_input_strobe = ibs_reg;
  assign end_of_input_flag = eoi_reg;

  assign fill_char   = fill_reg;
  assign tx_buf_data = txbuf_reg;
  assign tx_buf_load = txld_reg;
  assign sync_match  = sync_reg;
  assign rx_resync   = resync_reg;

  // Home is only meaningful while the strobe is high
  assign display_data   = disp_reg[DISP_HOME-1:0];
  assign display_strobe = dstb_reg;
  assign display_home   = dstb_reg & disp_reg[DISP_HOME];

  assign tx_mode        = txf_reg[FMT_MODE_LO +: 2];
  assign tx_char_bits   = txf_reg[FMT_SIZE_LO +: 2];
  assign tx_parity_en   = ~txf_reg[FMT_PAR_EN_N];
  assign tx_parity_even = txf_reg[FMT_PAR_EVEN];
  assign tx_div         = txf_reg[FMT_DIV_LO +: 2];

  assign rx_sync_mode   = rxf_reg[FMT_MODE_LO];
  assign rx_char_bits   = rxf_reg[FMT_SIZE_LO +: 2];
  assign rx_parity_en   = ~rxf_reg[FMT_PAR_EN_N];
  assign rx_parity_even = rxf_reg[FMT_PAR_EVEN];
  assign rx_div         = rxf_reg[FMT_DIV_LO +: 2];
  assign rx_serial_in   = loop_reg;

  assign reset_key_flag = rkey_reg;
  assign tick_flag      = tick_reg;
  assign tx_underflow   = unf_reg;
  assign rx_overflow    = ovf_reg;
  assign parity_err     = par_reg;
  assign framing_err    = frm_reg;
  assign tx_ready       = txr_reg;
  assign irq = (rx_int_en & rx_ready) | (tx_int_en & txr_reg);

endmodule // ccio_io_decode

// ==== ccio_pkg.sv ====
// Functional notes
// - Operand bits 7-3 are control strobes; bits 2-0 select the operation.
// - Operand bit 7 on any I/O instruction clears the reset-key flag.
// - Operand bit 6 makes the receiver drop sync and hunt for sync match.
// - Operand bit 5 on any I/O instruction clears the periodic tick flag.
// - Operand bit 4 sets end-of-input on host data output only.
// - Operand bit 3 clears underflow, overflow, parity and framing flags.
// - Output 000 loads RTS, DTR, both interrupt enables and supervisory data.
// - Data-link control bits 5 to 7 select the nominal serial rate.
// - Rate code 111 takes the bit clock from modem element timing inputs.
// - Output 001 drives the host input bus with strobe and end-of-input bit.
// - Output 010 stores the transmitter fill character.
// - Output 011 loads transmit buffer and clears transmitter ready.
// - Output 100 sends display byte with strobe; bit 7 is home strobe.
// - Output 101 stores the receiver sync-match character.
// - Output 110 loads transmitter control; bits 0-1 select mode.
// - Transmitter control bits 6-7 divide the rate by 1, 16, 32, 64.
// - Receiver control bit 0 async/sync; bits 2-7 as transmitter encoding.
// - A self-test path loops serial output back into the receiver.
// - Interrupt when an enable and its matching ready are both set.
// - Tick flag sets every 8 ms and holds until cleared.
// - Reset-key flag sets on host reset key, holds until cleared.
package ccio_pkg;

  localparam int unsigned CLK_HZ_DEF   = 50_000_000;
  localparam int unsigned TICK_TIME_US = 8000;
  localparam int unsigned TICK_CYCLES_DEF =
    (CLK_HZ_DEF / 1_000_000) * TICK_TIME_US;

  // Operand layout
  localparam int OPB_CLR_RESET_KEY = 7;
  localparam int OPB_SYNC_SEARCH   = 6;
  localparam int OPB_CLR_TICK      = 5;
  localparam int OPB_END_OF_INPUT  = 4;
  localparam int OPB_CLR_ERRORS    = 3;
  localparam int OPB_CODE_HI       = 2;

  // Output operation codes (register offsets)
  localparam logic [2:0] OP_DATA_LINK_CONTROL = 3'h0;
  localparam logic [2:0] OP_HOST_OUTPUT_DATA  = 3'h1;
  localparam logic [2:0] OP_TX_FILL_CHARACTER = 3'h2;
  localparam logic [2:0] OP_TX_DATA_BUFFER    = 3'h3;
  localparam logic [2:0] OP_DISPLAY_OUTPUT    = 3'h4;
  localparam logic [2:0] OP_RX_SYNC_MATCH     = 3'h5;
  localparam logic [2:0] OP_TX_FORMAT_CONTROL = 3'h6;
  localparam logic [2:0] OP_RX_FORMAT_CONTROL = 3'h7;

  // Data-link control fields
  localparam int DLC_RTS = 0;
  localparam int DLC_DTR = 1;
  localparam int DLC_TX_IE = 2;
  localparam int DLC_RX_IE = 3;
  localparam int DLC_SUP_TX = 4;
  localparam int DLC_RATE_LO = 5;
  localparam logic [2:0] RATE_EXTERNAL = 3'h7;

  // Format control fields
  localparam int FMT_MODE_LO = 0;
  localparam int FMT_SIZE_LO = 2;
  localparam int FMT_PAR_EN_N = 5;
  localparam int FMT_PAR_EVEN = 4;
  localparam int FMT_DIV_LO = 6;
  localparam int DISP_HOME = 7;

  localparam logic [7:0] DLC_RESET = 8'h00;
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] CHAR_RESET = 8'h00;

  // Nominal rates in tenths of a baud
  localparam int unsigned RATE_X10 [7] = '{
    17588, 21533, 24000, 32000, 192000, 1152000, 1536000};

  localparam logic [1:0] DIV_1  = 2'h0;
  localparam logic [1:0] DIV_16 = 2'h1;
  localparam logic [1:0] DIV_32 = 2'h2;
  localparam logic [1:0] DIV_64 = 2'h3;

  function automatic logic [6:0] ccio_divisor(input logic [1:0] d);
    unique case (d)
      DIV_1:   ccio_divisor = 7'h01;
      DIV_16:  ccio_divisor = 7'h10;
      DIV_32:  ccio_divisor = 7'h20;
      DIV_64:  ccio_divisor = 7'h40;
    endcase
  endfunction

  function automatic logic [31:0] ccio_base_cycles(
    input logic [2:0] sel, input int unsigned clk_hz);
    logic [63:0] c;
    c = 64'(clk_hz) * 64'd10;
    c = c / 64'(RATE_X10[sel == RATE_EXTERNAL ? 3'h0 : sel]);
    ccio_base_cycles = (c == 64'd0) ? 32'h1 : c[31:0];
  endfunction

endpackage

// ==== ccio_tick_timer.sv ====
module ccio_tick_timer
  import ccio_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)(
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      tick
);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("TICK_CYCLES must be at least 2");
  end

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb
  begin
    tick_next = (cnt_reg == 32'(TICK_CYCLES - 1));
    cnt_next  = tick_next ? 32'h0 : cnt_reg + 32'h1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule // ccio_tick_timer

// ==== ccio_rate_gen.sv ====
module ccio_rate_gen
  import ccio_pkg::*;
#(
  parameter int unsigned CLK_HZ = CLK_HZ_DEF
)(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] rate_sel,
  input  wire logic [1:0] div_sel,
  input  wire logic       ext_timing,
  output logic            bit_tick
);

  if (CLK_HZ < 200_000) begin : g_chk
    $error("CLK_HZ too low for the fastest rate");
  end

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic [6:0]  pre_reg;
  logic [6:0]  pre_next;
  logic        ext_d_reg;
  logic        tick_reg;
  logic        tick_next;
  logic        base;

  always_comb
  begin
    // Modem timing counts on its one-to-zero edge
    if (rate_sel == RATE_EXTERNAL)
    begin
      base     = ext_d_reg & ~ext_timing;
      cnt_next = 32'h0;
    end
    else
    begin
      base     = (cnt_reg >= ccio_base_cycles(rate_sel, CLK_HZ) - 32'h1);
      cnt_next = base ? 32'h0 : cnt_reg + 32'h1;
    end
    tick_next = 1'b0;
    pre_next  = pre_reg;
    if (base)
    begin
      tick_next = (pre_reg >= ccio_divisor(div_sel) - 7'h1);
      pre_next  = tick_next ? 7'h0 : pre_reg + 7'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_reg   <= 32'h0;
      pre_reg   <= 7'h0;
      ext_d_reg <= 1'b0;
      tick_reg  <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      pre_reg   <= pre_next;
      ext_d_reg <= ext_timing;
      tick_reg  <= tick_next;
    end
  end

  assign bit_tick = tick_reg;

endmodule // ccio_rate_gen

// ==== ccio_cpu_model.sv ====
module ccio_cpu_model (
  input  wire logic       clk,
  output logic            io_strobe,
  output logic            io_output,
  output logic [7:0]      io_operand,
  output logic [7:0]      io_acc
);
  timeunit 1ns;
  timeprecision 1ns;

  time rel_t = 0;

  initial {io_strobe, io_output, io_operand, io_acc} = '0;

  // Call 1 ns after an edge; fin low keeps the next one back to back
  task automatic issue(input logic o, input logic [7:0] op, a,
                       input bit fin);
    // Released in this step: let an edge pass first
    if (rel_t == $time)
    begin
      @(posedge clk);
      #1;
    end
    io_strobe = 1'b1;
    io_output = o;
    io_operand = op;
    io_acc = a;
    @(posedge clk);
    #1;
    if (fin)
    begin
      // Released lines carry junk so a stale byte cannot pass
      io_strobe = 1'b0;
      io_operand = ~op;
      io_acc = ~a;
      rel_t = $time;
    end
  endtask
endmodule // ccio_cpu_model

// ==== ccio_io_decode_monitor.sv ====
module ccio_io_decode_monitor
  import ccio_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       io_strobe,
  input wire logic       io_output,
  input wire logic [7:0] io_operand,
  input wire logic [7:0] io_acc,
  input wire logic       host_reset_key,
  input wire logic       tx_ready_set,
  input wire logic       rx_ready,
  input wire logic       self_test_en,
  input wire logic       tx_serial,
  input wire logic       rts,
  input wire logic       dtr,
  input wire logic       tx_int_en,
  input wire logic       rx_int_en,
  input wire logic       sup_tx_data,
  input wire logic [2:0] rate_sel,
  input wire logic       ext_clock_sel,
  input wire logic [7:0] host_bus_data,
  input wire logic       host_input_strobe,
  input wire logic       end_of_input_flag,
  input wire logic [7:0] tx_buf_data,
  input wire logic       tx_buf_load,
  input wire logic       rx_resync,
  input wire logic [6:0] display_data,
  input wire logic       display_strobe,
  input wire logic       display_home,
  input wire logic [1:0] tx_mode,
  input wire logic [1:0] tx_char_bits,
  input wire logic       tx_parity_en,
  input wire logic       tx_parity_even,
  input wire logic [1:0] tx_div,
  input wire logic       rx_sync_mode,
  input wire logic [1:0] rx_char_bits,
  input wire logic       rx_parity_en,
  input wire logic       rx_parity_even,
  input wire logic [1:0] rx_div,
  input wire logic       rx_serial_in,
  input wire logic       reset_key_flag,
  input wire logic       tx_ready,
  input wire logic       irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire       wr = io_strobe && io_output;
  wire [2:0] op = io_operand[2:0];

  a_host_out: assert property (wr && op == 3'h1 |=> host_input_strobe
    && host_bus_data == $past(io_acc)
    && end_of_input_flag == $past(io_operand[4]))
    else $error("host output byte wrong");
  a_eoi_hold: assert property (!(wr && op == 3'h1) |=>
    $stable(end_of_input_flag)) else $error("end flag moved");
  a_strobe_cause: assert property (host_input_strobe |->
    $past(wr) && $past(op) == 3'h1) else $error("stray host strobe");
  a_link_load: assert property (wr && op == 3'h0 |=>
    {rate_sel, sup_tx_data, rx_int_en, tx_int_en, dtr, rts}
    == $past(io_acc)) else $error("link control wrong");
  a_ext_rate: assert property (ext_clock_sel ==
    (rate_sel == RATE_EXTERNAL)) else $error("external clock select");
  a_txbuf_load: assert property (wr && op == 3'h3 && !tx_ready_set
    |=> tx_buf_load && !tx_ready && tx_buf_data == $past(io_acc))
    else $error("tx buffer load wrong");
  a_display_out: assert property (wr && op == 3'h4 |=>
    display_strobe && display_home == $past(io_acc[7])
    && display_data == $past(io_acc[6:0])) else $error("display wrong");
  a_tx_format: assert property (wr && op == 3'h6 |=>
    {tx_div, tx_parity_en, tx_parity_even, tx_char_bits, tx_mode}
    == ($past(io_acc) ^ 8'h20)) else $error("tx format wrong");
  a_rx_format: assert property (wr && op == 3'h7 |=>
    {rx_div, rx_parity_en, rx_parity_even, rx_char_bits, 1'b0,
    rx_sync_mode} == (($past(io_acc) ^ 8'h20) & 8'hfd))
    else $error("rx format wrong");
  a_resync_pulse: assert property (rx_resync ==
    ($past(io_strobe) && $past(io_operand[6]))) else $error("resync");
  a_reskey_clear: assert property (io_strobe && io_operand[7]
    && !host_reset_key |=> !reset_key_flag) else $error("key not clear");
  a_reskey_set: assert property (host_reset_key |=> reset_key_flag)
    else $error("key flag not set");
  a_loop_back: assert property (self_test_en |=>
    rx_serial_in == $past(tx_serial)) else $error("loopback wrong");
  a_irq_level: assert property (irq ==
    (rx_int_en && rx_ready || tx_int_en && tx_ready))
    else $error("interrupt wrong");

  c_host_end: cover property (host_input_strobe && end_of_input_flag);
  c_disp_home: cover property (display_home);
  c_ready_win: cover property (wr && op == 3'h3 && tx_ready_set);
  c_ext_clock: cover property (ext_clock_sel);
endmodule // ccio_io_decode_monitor

bind ccio_io_decode ccio_io_decode_monitor mon_u (.*);

// ==== ccio_io_decode_tb.sv ====
module ccio_io_decode_tb
  import ccio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Low clock figure keeps rate periods short
  localparam int CLK_T = 200000;
  localparam int TICKS = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic io_strobe, io_output, rx_ready, tx_timing, rx_timing;
  logic [7:0] io_operand, io_acc, a, o, v;
  logic host_reset_key, tx_underflow_set, rx_overflow_set, parity_err_set;
  logic framing_err_set, tx_ready_set, self_test_en, tx_serial;
  logic modem_rx_data, rts, dtr, tx_int_en, rx_int_en, sup_tx_data;
  logic ext_clock_sel, host_input_strobe, end_of_input_flag, tx_buf_load;
  logic rx_resync, display_strobe, display_home, tx_parity_en;
  logic tx_parity_even, rx_sync_mode, rx_parity_en, rx_parity_even;
  logic tx_bit_tick, rx_bit_tick, rx_serial_in, reset_key_flag, tick_flag;
  logic tx_underflow, rx_overflow, parity_err, framing_err, tx_ready, irq;
  logic [2:0] rate_sel;
  logic [7:0] host_bus_data, fill_char, tx_buf_data, sync_match;
  logic [6:0] display_data;
  logic [1:0] tx_mode, tx_char_bits, tx_div, rx_char_bits, rx_div;
  logic [5:0] sets = 6'h00;
  logic [4:0] cfg [8] = '{5'h10, 5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c,
                          5'h1d, 5'h00};
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'h3253;
  int ph = 0;
  int n, t, r;
  wire [5:0] flags = {reset_key_flag, tx_underflow, rx_overflow,
                      parity_err, framing_err, tx_ready};
  wire [6:0] rx_fmt = {rx_div, rx_parity_en, rx_parity_even, rx_char_bits,
                       rx_sync_mode};
  assign {host_reset_key, tx_underflow_set, rx_overflow_set,
          parity_err_set, framing_err_set, tx_ready_set} = sets;

  always #10 clk = ~clk;

  ccio_cpu_model cpu_u (.clk, .io_strobe, .io_output, .io_operand, .io_acc);

  ccio_io_decode #(.CLK_HZ(CLK_T), .TICK_CYCLES(TICKS)) dut_u (
    .clk, .sys_rst, .io_strobe, .io_output, .io_operand, .io_acc,
    .host_reset_key, .tx_underflow_set, .rx_overflow_set, .parity_err_set,
    .framing_err_set, .tx_ready_set, .rx_ready, .tx_timing, .rx_timing,
    .self_test_en, .tx_serial, .modem_rx_data, .rts, .dtr, .tx_int_en,
    .rx_int_en, .sup_tx_data, .rate_sel, .ext_clock_sel, .host_bus_data,
    .host_input_strobe, .end_of_input_flag, .fill_char, .tx_buf_data,
    .tx_buf_load, .sync_match, .rx_resync, .display_data, .display_strobe,
    .display_home, .tx_mode, .tx_char_bits, .tx_parity_en, .tx_parity_even,
    .tx_div, .rx_sync_mode, .rx_char_bits, .rx_parity_en, .rx_parity_even,
    .rx_div, .tx_bit_tick, .rx_bit_tick, .rx_serial_in, .reset_key_flag,
    .tick_flag, .tx_underflow, .rx_overflow, .parity_err, .framing_err,
    .tx_ready, .irq);

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chkn(input int got, lo, hi, input string m);
    comparisons++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s count %0d", $time, m, got);
    end
  endtask

  task automatic stop_test;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Modem timing falls once per 8 cycles while counting
  task automatic count(input int len, output int tc, rc);
    tc = 0;
    rc = 0;
    repeat (len)
    begin
      ph++;
      tx_timing = ph[2];
      rx_timing = ph[2];
      cyc(1);
      tc += int'(tx_bit_tick);
      rc += int'(rx_bit_tick);
    end
  endtask

  task automatic wait_tick(output int k);
    k = 0;
    while (tick_flag !== 1'b1 && k < TICKS + 4)
    begin
      cyc(1);
      k++;
    end
  endtask

  function automatic int per(input logic [2:0] s, input logic [1:0] d);
    int b;
    b = (s == 3'h7) ? 8 : CLK_T * 10 / int'(RATE_X10[s]);
    return (b > 0 ? b : 1) << (d == 2'h0 ? 0 : d + 3);
  endfunction

  initial
  begin
    {rx_ready, tx_timing, rx_timing, self_test_en, tx_serial} = '0;
    modem_rx_data = 1'b1;
    cyc(12);
    sys_rst = 1'b0;
    cyc(1);
    chk({rts, dtr, tx_int_en, rx_int_en, sup_tx_data, rate_sel}, 0, "rst");
    chk({tx_ready, rx_serial_in, irq, tx_buf_load, reset_key_flag},
        5'h18, "rst flags");
    for (int i = 0; i < 64; i++)
    begin
      a = 8'($random(seed));
      o = (8'($random(seed)) & 8'h50) | 8'(i % 8);
      if (i % 8 == 0)
        a[7:5] = 3'(i / 8);
      cpu_u.issue(1'b1, o, a, i[0]);
      chk(rx_resync, o[6], "resync");
      case (o[2:0])
        3'h0: chk({ext_clock_sel, rts}, {a[7:5] == 3'h7, a[0]}, "ext");
        3'h1: chk({host_input_strobe, end_of_input_flag, host_bus_data},
                  {1'b1, o[4], a}, "host");
        3'h2: chk(fill_char, a, "fill");
        3'h3: chk({tx_buf_load, tx_ready, tx_buf_data},
                  {2'b10, a}, "tb");
        3'h4: chk({display_strobe, display_home, display_data},
                  {1'b1, a}, "disp");
        3'h5: chk(sync_match, a, "sync");
        3'h6: chk({tx_div, tx_parity_en, tx_parity_even, tx_char_bits,
                  tx_mode}, a ^ 8'h20, "txf");
        default: chk(rx_fmt, {a[7:6], ~a[5], a[4:2], a[0]}, "rxf");
      endcase
    end
    v = host_bus_data;
    n = int'(end_of_input_flag);
    cpu_u.issue(1'b0, {3'h0, ~end_of_input_flag, 4'h1}, ~v, 1'b1);
    chk({host_input_strobe, end_of_input_flag, host_bus_data},
        {1'b0, n[0], v}, "input ignored");
    sets = 6'h3f;
    cyc(1);
    sets = 6'h02;
    chk(flags, 6'h3f, "set");
    cpu_u.issue(1'b0, 8'h88, 8'h00, 1'b1);
    sets = 6'h01;
    chk(flags, 6'h03, "clear, set wins");
    cpu_u.issue(1'b1, 8'h0b, 8'h77, 1'b1);
    sets = 6'h00;
    chk(flags, 6'h01, "ready wins");
    rx_ready = 1'b1;
    cpu_u.issue(1'b1, 8'h00, 8'h08, 1'b1);
    chk(irq, 1'b1, "irq rx");
    rx_ready = 1'b0;
    cpu_u.issue(1'b1, 8'h00, 8'h04, 1'b1);
    chk(irq, 1'b1, "irq tx");
    cpu_u.issue(1'b1, 8'h03, 8'h00, 1'b1);
    chk(irq, 1'b0, "irq off");
    wait_tick(n);
    cpu_u.issue(1'b0, 8'h20, 8'h00, 1'b1);
    wait_tick(n);
    cpu_u.issue(1'b1, 8'h25, 8'h00, 1'b1);
    chk(tick_flag, 1'b0, "tick clear");
    wait_tick(n);
    chkn(n, TICKS - 2, TICKS, "tick period");
    for (int i = 0; i < 16; i++)
    begin
      self_test_en = i[3];
      tx_serial = 1'($random(seed));
      modem_rx_data = ~tx_serial;
      v[0] = i[3] ? tx_serial : modem_rx_data;
      cyc(1);
      chk(rx_serial_in, v[0], "loop");
    end
    foreach (cfg[k])
    begin
      cpu_u.issue(1'b1, 8'h00, {cfg[k][4:2], 5'h00}, 1'b0);
      cpu_u.issue(1'b1, 8'h06, {cfg[k][1:0], 6'h0c}, 1'b0);
      cpu_u.issue(1'b1, 8'h07, {cfg[k][1:0], 6'h0c}, 1'b1);
      n = per(cfg[k][4:2], cfg[k][1:0]);
      count(2 * n + 130, t, r);
      count(8 * n, t, r);
      chkn(t, 7, 9, "tx rate");
      chkn(r, 7, 9, "rx rate");
    end
    stop_test();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    stop_test();
  end
endmodule // ccio_io_decode_tb
